//--- hw/remap_decode_pkg.sv
// Purpose: Constants for the remap entry low-bit decoder
// Assumes: Entry low control bits arrive as a byte with each request
// Notes:   Bit positions follow the entry layout
package remap_decode_pkg;
    localparam int unsigned PRESENT_BIT      = 0;
    localparam int unsigned SUPPRESS_BIT     = 1;
    localparam int unsigned FORMAT_BIT       = 2;
    localparam int unsigned HINT_BIT         = 3;
    localparam int unsigned CTRL_W           = 8;
    localparam int unsigned DEST_W_DEF       = 8;
    localparam int unsigned TARGETS_DEF      = 8;
    localparam logic        RESET_BIT        = 1'b0;
endpackage

//--- hw/remap_entry_decode.sv
// Purpose: Decode present, fault-suppress, format and hint bits of a remap entry
// Assumes: One request per cycle, req_valid_i a one-cycle strobe; one cycle latency
// Notes:   Hint selection rotates among candidate targets named by a bit mask
// Functional notes
// R1: Entry not present blocks every request referencing it; nothing delivered.
// R2: Entry present means request processed per the other programmed fields.
// R3: Suppress bit zero means faults from this entry are recorded and reported.
// R4: Suppress bit one means faults from this entry are neither recorded nor reported.
// R5: Suppress bit evaluated for every request, also for blocked ones.
// R6: Format bit zero means physical target ID, one means logical ID.
// R7: Hint zero sends interrupt to the processor named by the destination.
// R8: Hint one sends to exactly one hardware-chosen of the N named processors.
// R9: Hint and format bits ignored unless the entry is present.
// R10: Blocked request raises a fault event only when suppress bit is zero.
`timescale 1ns/10ps
`default_nettype none
module remap_entry_decode #(
    parameter int unsigned DEST_W  = remap_decode_pkg::DEST_W_DEF,
    parameter int unsigned TARGETS = remap_decode_pkg::TARGETS_DEF
) (
    input  wire logic                                 mclk_i,
    input  wire logic                                 rst_n_i,
    input  wire logic                                 req_valid_i,
    input  wire logic [remap_decode_pkg::CTRL_W-1:0]  remap_table_entry_i,
    input  wire logic [DEST_W-1:0]                    dest_id_i,
    input  wire logic [TARGETS-1:0]                   target_set_i,
    input  wire logic                                 fault_i,
    output logic                                      deliver_o,
    output logic                                      blocked_o,
    output logic                                      target_id_format_o,
    output logic                                      redirection_hint_o,
    output logic [DEST_W-1:0]                         dest_id_o,
    output logic [TARGETS-1:0]                        target_sel_o,
    output logic                                      fault_event_o
);
    typedef struct packed {
        logic               deliver;
        logic               blocked;
        logic               fmt;
        logic               hint;
        logic [DEST_W-1:0]  dest;
        logic [TARGETS-1:0] sel;
        logic               fault;
        logic [TARGETS-1:0] rr;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic   rst_meta_reg;
    logic   rst_sync_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Lowest candidate at or above the one-hot pointer, else wrap to the
    // lowest candidate; an empty set grants nothing
    function automatic logic [TARGETS-1:0] pick_one(input logic [TARGETS-1:0] cand,
                                                    input logic [TARGETS-1:0] ptr);
        logic [TARGETS-1:0] upper;
        logic [TARGETS-1:0] pool;
        if (ptr == '0) begin
            upper = cand;
        end else begin
            upper = cand & ~(ptr - TARGETS'(1));
        end
        pool     = (upper != '0) ? upper : cand;
        pick_one = pool & (~pool + TARGETS'(1));
    endfunction

    logic present;
    logic suppress;
    logic [TARGETS-1:0] grant;

    always_comb begin
        state_next = state_reg;
        present    = remap_table_entry_i[remap_decode_pkg::PRESENT_BIT];
        suppress   = remap_table_entry_i[remap_decode_pkg::SUPPRESS_BIT];
        grant      = pick_one(target_set_i, state_reg.rr);
        state_next.deliver = req_valid_i && present;                  // see R1 see R2
        state_next.blocked = req_valid_i && !present;                 // see R1
        // Suppress read regardless of present; blocked requests fault too
        state_next.fault   = req_valid_i && !suppress && (fault_i || !present); // see R3 see R4 see R5 see R10
        if (req_valid_i && present) begin                              // see R9
            state_next.fmt  = remap_table_entry_i[remap_decode_pkg::FORMAT_BIT]; // see R6
            state_next.hint = remap_table_entry_i[remap_decode_pkg::HINT_BIT];
            state_next.dest = dest_id_i;
            if (remap_table_entry_i[remap_decode_pkg::HINT_BIT]) begin
                state_next.sel = grant;                                // see R8
                if (grant != '0) begin
                    state_next.rr = {grant[TARGETS-2:0], grant[TARGETS-1]};
                end
            end else begin
                state_next.sel = '0;                                   // see R7
            end
        end else if (req_valid_i) begin
            state_next.fmt  = remap_decode_pkg::RESET_BIT;
            state_next.hint = remap_decode_pkg::RESET_BIT;
            state_next.sel  = '0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign deliver_o          = state_reg.deliver;
    assign blocked_o          = state_reg.blocked;
    assign target_id_format_o = state_reg.fmt;
    assign redirection_hint_o = state_reg.hint;
    assign dest_id_o          = state_reg.dest;
    assign target_sel_o       = state_reg.sel;
    assign fault_event_o      = state_reg.fault;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_sync_reg);

    // Entry bits read straight off the input, so a decode slip is not shared
    block_absent_a: assert property ( // see R1
        req_valid_i && !remap_table_entry_i[remap_decode_pkg::PRESENT_BIT]
        |=> blocked_o && !deliver_o)
        else $error("Non-present request not blocked");

    deliver_present_a: assert property ( // see R2
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT]
        |=> deliver_o && !blocked_o)
        else $error("Present request not delivered");

    idle_silent_a: assert property ( // see R2
        !req_valid_i
        |=> !deliver_o && !blocked_o && !fault_event_o)
        else $error("Pulse raised without a request");

    fault_report_a: assert property ( // see R3
        req_valid_i && !remap_table_entry_i[remap_decode_pkg::SUPPRESS_BIT] && fault_i
        |=> fault_event_o)
        else $error("Fault not reported");

    clean_no_fault_a: assert property ( // see R3
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT] && !fault_i
        |=> !fault_event_o)
        else $error("Fault reported for a clean request");

    fault_quiet_a: assert property ( // see R4
        req_valid_i && remap_table_entry_i[remap_decode_pkg::SUPPRESS_BIT]
        |=> !fault_event_o)
        else $error("Suppressed fault reported");

    suppress_blocked_a: assert property ( // see R5
        req_valid_i && !remap_table_entry_i[remap_decode_pkg::PRESENT_BIT] &&
        remap_table_entry_i[remap_decode_pkg::SUPPRESS_BIT]
        |=> blocked_o && !fault_event_o)
        else $error("Suppress ignored on blocked request");

    format_follow_a: assert property ( // see R6
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT]
        |=> target_id_format_o == $past(remap_table_entry_i[remap_decode_pkg::FORMAT_BIT]))
        else $error("Format bit not passed");

    fmt_hold_a: assert property ( // see R6
        !req_valid_i
        |=> $stable(target_id_format_o) && $stable(redirection_hint_o))
        else $error("Format or hint changed without a request");

    direct_target_a: assert property ( // see R7
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT] &&
        !remap_table_entry_i[remap_decode_pkg::HINT_BIT]
        |=> target_sel_o == '0 && dest_id_o == $past(dest_id_i))
        else $error("Direct target wrong");

    one_target_a: assert property ( // see R8
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT] &&
        remap_table_entry_i[remap_decode_pkg::HINT_BIT] && target_set_i != '0
        |=> $onehot(target_sel_o) && (target_sel_o & $past(target_set_i)) != '0)
        else $error("Hint did not pick exactly one candidate");

    hint_follow_a: assert property ( // see R8
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT]
        |=> redirection_hint_o == $past(remap_table_entry_i[remap_decode_pkg::HINT_BIT]))
        else $error("Hint bit not passed");

    empty_set_a: assert property ( // see R8
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT] &&
        remap_table_entry_i[remap_decode_pkg::HINT_BIT] && target_set_i == '0
        |=> target_sel_o == '0)
        else $error("Empty candidate set produced a pick");

    sel_hold_a: assert property ( // see R8
        !req_valid_i
        |=> $stable(target_sel_o) && $stable(dest_id_o))
        else $error("Pick or destination changed without a request");

    ignore_absent_a: assert property ( // see R9
        req_valid_i && !remap_table_entry_i[remap_decode_pkg::PRESENT_BIT]
        |=> !redirection_hint_o && !target_id_format_o)
        else $error("Hint or format used while absent");

    absent_no_sel_a: assert property ( // see R9
        req_valid_i && !remap_table_entry_i[remap_decode_pkg::PRESENT_BIT]
        |=> target_sel_o == '0)
        else $error("Pick made for an absent entry");

    dest_hold_a: assert property ( // see R9
        req_valid_i && !remap_table_entry_i[remap_decode_pkg::PRESENT_BIT]
        |=> $stable(dest_id_o))
        else $error("Destination taken from an absent entry");

    blocked_fault_a: assert property ( // see R10
        req_valid_i && !remap_table_entry_i[remap_decode_pkg::PRESENT_BIT] &&
        !remap_table_entry_i[remap_decode_pkg::SUPPRESS_BIT]
        |=> fault_event_o)
        else $error("Blocked request raised no fault");

    deliver_c:    cover property (
        req_valid_i && remap_table_entry_i[remap_decode_pkg::PRESENT_BIT] ##1 deliver_o);
    blocked_c:    cover property (blocked_o && fault_event_o);
    suppressed_c: cover property (blocked_o && !fault_event_o);
    hint_c:       cover property (deliver_o && redirection_hint_o && target_sel_o != '0);
    logical_c:    cover property (deliver_o && target_id_format_o);
endmodule
`default_nettype wire

//--- testbench/io_requester.sv
// Purpose: Model of an I/O agent issuing remap requests
// Assumes: Caller runs one time unit after a rising edge
// Notes:   Idle inverts entry and destination data; set and fault lines keep their last values
`timescale 1ns/10ps
`default_nettype none
module io_requester (
    input  wire logic       mclk_i,
    output logic            req_valid_o,
    output logic [7:0]      entry_o,
    output logic [7:0]      dest_o,
    output logic [7:0]      set_o,
    output logic            fault_o
);
    initial begin
        {req_valid_o, entry_o, dest_o, set_o, fault_o} = '0;
    end
    task automatic send(input logic [7:0] e, input logic [7:0] d, input logic [7:0] s,
                        input logic f);
        {req_valid_o, entry_o, dest_o, set_o, fault_o} = {1'b1, e, d, s, f};
        @(posedge mclk_i);
        #1;
    endtask
    task automatic idle();
        {req_valid_o, entry_o, dest_o} = {1'b0, ~entry_o, ~dest_o};
        @(posedge mclk_i);
        #1;
    endtask
endmodule
`default_nettype wire

//--- testbench/remap_entry_decode_tb.sv
// Purpose: Directed checks of the remap entry low-bit decoder
// Assumes: Default widths of eight; candidate set given with each request
// Notes:   Requests run back to back to catch stale registered state
`timescale 1ns/10ps
`default_nettype none
module remap_entry_decode_tb;
    logic        mclk, rst_n, req_valid, fault, deliver, blocked, fmt, hint, fault_ev;
    logic [7:0]  entry, dest, set, dest_q, sel;
    int          errors = 0;
    int          num_checks = 0;
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    io_requester u_req (.mclk_i(mclk), .req_valid_o(req_valid), .entry_o(entry),
        .dest_o(dest), .set_o(set), .fault_o(fault));
    remap_entry_decode u_dut (.mclk_i(mclk), .rst_n_i(rst_n), .req_valid_i(req_valid),
        .remap_table_entry_i(entry), .dest_id_i(dest), .target_set_i(set),
        .fault_i(fault), .deliver_o(deliver), .blocked_o(blocked),
        .target_id_format_o(fmt), .redirection_hint_o(hint), .dest_id_o(dest_q),
        .target_sel_o(sel), .fault_event_o(fault_ev));
    task automatic check(input logic [20:0] exp);
        num_checks++;
        if ({deliver, blocked, fmt, hint, fault_ev, sel, dest_q} !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time,
                {deliver, blocked, fmt, hint, fault_ev, sel, dest_q}, exp);
        end
    endtask
    task automatic step(input logic [7:0] e, input logic [7:0] d, input logic [7:0] s,
                        input logic f, input logic [20:0] exp);
        u_req.send(e, d, s, f);
        check(exp);
    endtask
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check({5'b00000, 8'h00, 8'h00});
        // Fields: deliver, blocked, format, hint, fault event, pick, destination
        step(8'h01, 8'h5a, 8'h0c, 1'b0, {5'b10000, 8'h00, 8'h5a});
        step(8'h05, 8'ha5, 8'h0c, 1'b1, {5'b10101, 8'h00, 8'ha5});
        step(8'h07, 8'ha5, 8'h0c, 1'b1, {5'b10100, 8'h00, 8'ha5});
        step(8'h09, 8'h3c, 8'h0c, 1'b0, {5'b10010, 8'h04, 8'h3c});
        step(8'h09, 8'h3c, 8'h0c, 1'b0, {5'b10010, 8'h08, 8'h3c});
        step(8'h09, 8'h3c, 8'h0c, 1'b0, {5'b10010, 8'h04, 8'h3c});
        step(8'h0d, 8'h77, 8'h00, 1'b0, {5'b10110, 8'h00, 8'h77});
        step(8'h0d, 8'h77, 8'h81, 1'b0, {5'b10110, 8'h80, 8'h77});
        step(8'h0c, 8'h11, 8'h0c, 1'b0, {5'b01001, 8'h00, 8'h77});
        step(8'h0e, 8'h11, 8'h0c, 1'b1, {5'b01000, 8'h00, 8'h77});
        u_req.idle();
        check({5'b00000, 8'h00, 8'h77});
        wrap_up();
    end
endmodule
`default_nettype wire
